/* File: cbicc_top.v */
// Register access over APB was decided locally.
`timescale 1ns/1ns
`include "cbicc_map.vh"
module cbicc_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire card_clk_in,
    input wire card_access,
    input wire socket_idle,
    input wire host_clkrun_stopping,
    output reg card_clk_out,
    output reg card_clk_stopped,
    output reg irq
);
// states of the card clock
localparam ST_RUN = 2'b00;
localparam ST_STOP = 2'b01;
localparam ST_SLOW = 2'b10;

reg clock_policy_enable;
reg idle_slow_select;
reg idle_only_gate_policy;
reg card_access_seen;
reg clock_rate_changed;
reg [1:0] irq_status;
reg [1:0] irq_enable;
reg [1:0] state;
reg [1:0] next_state;
reg [3:0] div_cnt;
reg clk_d;
reg access_d;
reg [31:0] next_rdata;
wire clk_s;
wire access_s;
wire idle_s;
wire host_stop_s;
wire clk_rise;
wire access_pulse;
wire idle_ok;
wire setup;
wire rd_access;
wire wr_access;
wire pm_hit;
wire mapped;
wire mode_now;
wire [1:0] irq_event;
wire ctl_hit;
wire irq_stat_hit;
wire irq_clr_hit;
wire irq_en_hit;
wire [1:0] irq_clear;
wire [3:0] next_div;
reg next_clk_out;

// every asynchronous pin gets its own two-flop synchroniser before any logic reads it
// limitation: the card clock is sampled, not used as a clock, so it must stay
// well below half of pclk or edges are lost

cbicc_sync u_sync_clk (
    .pclk(pclk),
    .presetn(presetn),
    .din(card_clk_in),
    .dout(clk_s)
);
cbicc_sync u_sync_acc (
    .pclk(pclk),
    .presetn(presetn),
    .din(card_access),
    .dout(access_s)
);
cbicc_sync u_sync_idle (
    .pclk(pclk),
    .presetn(presetn),
    .din(socket_idle),
    .dout(idle_s)
);
cbicc_sync u_sync_host (
    .pclk(pclk),
    .presetn(presetn),
    .din(host_clkrun_stopping),
    .dout(host_stop_s)
);

// edge detectors read only the second flop of the clock and access synchronisers
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        clk_d <= 1'b0;
        access_d <= 1'b0;
    end
    else
    begin
        clk_d <= clk_s;
        access_d <= access_s;
    end
end
assign clk_rise = clk_s & ~clk_d;
assign access_pulse = access_s & ~access_d;

// apb: setup cycle, then one access cycle with pready high
assign setup = psel & ~penable;
assign rd_access = psel & penable & pready & ~pwrite;
assign wr_access = psel & penable & pready & pwrite;
assign pm_hit = (paddr == `CBICC_PM_OFFSET);
assign ctl_hit = (paddr == `CBICC_CTL_OFFSET);
assign irq_stat_hit = (paddr == `CBICC_IRQ_STATUS_OFFSET);
assign irq_clr_hit = (paddr == `CBICC_IRQ_CLEAR_OFFSET);
assign irq_en_hit = (paddr == `CBICC_IRQ_ENABLE_OFFSET);

// any other offset answers with pslverr, ignores writes and reads as zero
assign mapped = pm_hit | ctl_hit | irq_stat_hit | irq_clr_hit | irq_en_hit;

// zero wait states: pready is registered from the setup cycle,
// so every transfer takes exactly two cycles
// prdata is forced to zero outside the access cycle so stale data never shows

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end
    else
    begin
        pready <= setup;
        pslverr <= setup & ~mapped;
        prdata <= setup ? next_rdata : 32'h00000000;
    end
end


// read data is captured in the setup cycle, so the flag value shown is pre-clear
always @*
begin
    next_rdata = 32'h00000000;
    case (paddr)
        `CBICC_PM_OFFSET:
        begin
            next_rdata[`CBICC_BIT_ACCESS] = card_access_seen | access_pulse;
            next_rdata[`CBICC_BIT_MODE] = clock_rate_changed;
            next_rdata[`CBICC_BIT_ENABLE] = clock_policy_enable;
            next_rdata[`CBICC_BIT_SLOW] = idle_slow_select;
        end
        `CBICC_CTL_OFFSET:
            next_rdata[`CBICC_BIT_IDLE_ONLY] = idle_only_gate_policy;
        `CBICC_IRQ_STATUS_OFFSET:
            next_rdata[1:0] = irq_status;
        `CBICC_IRQ_ENABLE_OFFSET:
            next_rdata[1:0] = irq_enable;
        default:
            next_rdata = 32'h00000000;
    endcase
end


// control registers
// only the two writable bits of the power register store anything; bits 25 and 24 read status, the rest read zero
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        clock_policy_enable <= 1'b0;
        idle_slow_select <= 1'b0;
        idle_only_gate_policy <= 1'b0;
        irq_enable <= 2'b00;
    end
    else if (wr_access)
    begin
        if (pm_hit)
        begin
            clock_policy_enable <= pwdata[`CBICC_BIT_ENABLE];
            idle_slow_select <= pwdata[`CBICC_BIT_SLOW];
        end
        if (ctl_hit)
            idle_only_gate_policy <= pwdata[`CBICC_BIT_IDLE_ONLY];
        if (irq_en_hit)
            irq_enable <= pwdata[1:0];
    end
end


// access flag: a new access in the clearing cycle wins over the clear
// so that no access can be lost between a read and the next one
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        card_access_seen <= 1'b0;
    else if (access_pulse)
        card_access_seen <= 1'b1;
    else if (rd_access && pm_hit)
        card_access_seen <= 1'b0;
end

// clock-run may act only when the idle policy allows it
assign idle_ok = idle_s & (idle_only_gate_policy | host_stop_s);

// leaving STOP or SLOW is immediate once the conditions drop, so a busy card
// never waits on the divider
// a change of bit 0 while idle passes through RUN for one cycle

always @*
begin
    next_state = state;
    case (state)
        ST_RUN:
            if (clock_policy_enable && idle_ok)
                next_state = idle_slow_select ? ST_SLOW : ST_STOP;
        ST_STOP:
            if (!clock_policy_enable || !idle_ok || idle_slow_select)
                next_state = ST_RUN;
        ST_SLOW:
            if (!clock_policy_enable || !idle_ok || !idle_slow_select)
                next_state = ST_RUN;
        default:
            next_state = ST_RUN;
    endcase
end


// the divider runs in every state so that slow mode needs no warm-up
// trade-off: the first slow half period may be short, never long
assign next_div = (div_cnt == `CBICC_SLOW_DIV) ? 4'h0 : div_cnt + 4'h1;
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        div_cnt <= 4'h0;
    else if (clk_rise)
        div_cnt <= next_div;
end

// slow mode toggles the output every 8 input rises: one sixteenth of the frequency
always @*
begin
    case (state)
        ST_RUN:
            next_clk_out = clk_s;
        ST_STOP:
            next_clk_out = 1'b0;
        ST_SLOW:
            next_clk_out = div_cnt[3];
        default:
            next_clk_out = clk_s;
    endcase
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state <= ST_RUN;
        card_clk_out <= 1'b0;
        card_clk_stopped <= 1'b0;
    end
    else
    begin
        state <= next_state;
        card_clk_stopped <= (next_state == ST_STOP);
        card_clk_out <= next_clk_out;
    end
end


// mode status follows the actual gate/divider state
// the mode interrupt fires both on entering and on leaving a changed clock
assign mode_now = (state != ST_RUN);
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        clock_rate_changed <= 1'b0;
    else
        clock_rate_changed <= mode_now;
end

// interrupts: sticky status, set wins over write-one-to-clear
assign irq_event[`CBICC_IRQ_ACCESS] = access_pulse;
assign irq_event[`CBICC_IRQ_MODE] = mode_now ^ clock_rate_changed;

// write-one-to-clear mask; a zero bit leaves its status alone
assign irq_clear = (wr_access && irq_clr_hit) ? pwdata[1:0] : 2'b00;
genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_irq
        always @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                irq_status[gi] <= 1'b0;
            else if (irq_event[gi])
                irq_status[gi] <= 1'b1;
            else if (irq_clear[gi])
                irq_status[gi] <= 1'b0;
        end
    end
endgenerate


// level output, re-evaluated every cycle so masking takes effect on the next pclk edge
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        irq <= 1'b0;
    else
        irq <= |(irq_status & irq_enable);
end
endmodule // cbicc_top

/* File: cbicc_map.vh */
// Contract
// - power-management register sits at offset 20h and resets to all zeros
// - bit 25 sets whenever any access to the inserted card occurs
// - a register read clears bit 25, returning its value before clearing
// - bit 24 reads 1 while card clock frequency is changed, else 0
// - bit 16 enables bit 0; while bit 16 is 0 bit 0 has no effect
// - enabled with bit 0 clear: idle clock-run may stop the card clock
// - enabled with bit 0 set: idle clock-run slows card clock to one sixteenth
// - reserved bits 31-26, 23-17 and 15-1 always read as zero
// - idle-only policy clear needs host clock-run preparing to stop; set needs idle only
`ifndef CBICC_MAP_VH
`define CBICC_MAP_VH
`define CBICC_PM_OFFSET 12'h020
`define CBICC_CTL_OFFSET 12'h010
`define CBICC_IRQ_STATUS_OFFSET 12'h040
`define CBICC_IRQ_CLEAR_OFFSET 12'h044
`define CBICC_IRQ_ENABLE_OFFSET 12'h048
`define CBICC_PM_RESET 32'h00000000
`define CBICC_BIT_SLOW 0
`define CBICC_BIT_ENABLE 16
`define CBICC_BIT_MODE 24
`define CBICC_BIT_ACCESS 25
`define CBICC_BIT_IDLE_ONLY 7
`define CBICC_SLOW_DIV 4'hF
`define CBICC_IRQ_ACCESS 0
`define CBICC_IRQ_MODE 1
`endif

/* File: cbicc_sync.v */
`timescale 1ns/1ns
// two-flop synchroniser for a level from outside the pclk domain
module cbicc_sync (
    input wire pclk,
    input wire presetn,
    input wire din,
    output reg dout
);
reg meta;
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        meta <= 1'b0;
        dout <= 1'b0;
    end
    else
    begin
        meta <= din;
        dout <= meta;
    end
end
endmodule // cbicc_sync

/* File: cbicc_chk.sv */
`timescale 1ns/1ns
module cbicc_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire socket_idle,
    input wire card_clk_out,
    input wire card_clk_stopped,
    input wire irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire setup = psel && !penable;
    wire rd20 = pready && !pwrite && paddr == 12'h020;
    property p_rdy; setup |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready too long");
    property p_err; setup && paddr == 12'h0FC |=> pslverr; endproperty
    a_err: assert property (p_err) else $error("no slave error");
    property p_ok; setup && paddr == 12'h020 |=> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("spurious error");
    property p_rsv; rd20 |-> (prdata & 32'hFCFEFFFE) == 32'h00000000; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    // output lags the stop state by one register
    property p_gate; card_clk_stopped [*2] |-> !card_clk_out; endproperty
    a_gate: assert property (p_gate) else $error("clock runs while stopped");
    property p_busy; !socket_idle [*8] |-> !card_clk_stopped; endproperty
    a_busy: assert property (p_busy) else $error("stopped while busy");
    property p_mask; pready && pwrite && paddr == 12'h048 && pwdata == 0 |-> ##2 !irq; endproperty
    a_mask: assert property (p_mask) else $error("masked irq high");
endmodule // cbicc_chk

/* File: cbicc_card.sv */
`timescale 1ns/1ns
module cbicc_card (
    input wire hit,
    output logic card_clk_in,
    output logic card_access
);
    // odd start offset keeps the card clock out of phase with pclk
    initial
    begin
        card_clk_in = 1'h0;
        card_access = 1'h0;
        #37;
        forever
            #400 card_clk_in = ~card_clk_in;
    end
    // one access per request, wide enough for the two-flop sampler
    always @(posedge hit)
    begin
        card_access = 1'h1;
        #400 card_access = 1'h0;
    end
endmodule // cbicc_card

/* File: tb_cbicc_top.sv */
`timescale 1ns/1ns
module tb_cbicc_top;
    logic pclk, presetn, psel, penable, pwrite, socket_idle, host_clkrun_stopping, hit, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, rdat;
    wire [31:0] prdata;
    wire pready, pslverr, card_clk_in, card_access, card_clk_out, card_clk_stopped, irq;
    int n_mismatch, num_checks, cyc;
    cbicc_top u_dut (.*);
    cbicc_card u_card (.*);
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // extra edge at the end so back-to-back calls never re-drive psel in one step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1)
            @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task rc(input logic [11:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h00000000);
        chk("prdata", rdat, e);
    endtask
    task t_regs;
        rc(12'h020, 32'h00000000);
        apb(1'h1, 12'h020, 32'hFFFFFFFF);
        rc(12'h020, 32'h00010001);
        apb(1'h0, 12'h0FC, 32'h00000000);
        chk("pslverr", {31'h0, rerr}, 32'h00000001);
        apb(1'h1, 12'h020, 32'h00000000);
    endtask
    task t_acc;
        apb(1'h1, 12'h048, 32'h00000001);
        hit <= 1'h1;
        wt(8);
        hit <= 1'h0;
        chk("irq", {31'h0, irq}, 32'h00000001);
        rc(12'h020, 32'h02000000);
        rc(12'h020, 32'h00000000);
        rc(12'h040, 32'h00000001);
        apb(1'h1, 12'h048, 32'h00000000);
        wt(2);
        chk("irq", {31'h0, irq}, 32'h00000000);
        apb(1'h1, 12'h044, 32'h00000001);
        rc(12'h040, 32'h00000000);
    endtask
    task t_stop;
        apb(1'h1, 12'h020, 32'h00010000);
        socket_idle <= 1'h1;
        wt(20);
        chk("stopped", {31'h0, card_clk_stopped}, 32'h00000000);
        host_clkrun_stopping <= 1'h1;
        wt(20);
        chk("stopped", {31'h0, card_clk_stopped}, 32'h00000001);
        rc(12'h020, 32'h01010000);
        socket_idle <= 1'h0;
        host_clkrun_stopping <= 1'h0;
        wt(20);
        rc(12'h020, 32'h00010000);
        apb(1'h1, 12'h010, 32'h00000080);
        socket_idle <= 1'h1;
        wt(20);
        chk("stopped", {31'h0, card_clk_stopped}, 32'h00000001);
        socket_idle <= 1'h0;
        wt(20);
    endtask
    task t_slow;
        int n;
        apb(1'h1, 12'h020, 32'h00000001);
        socket_idle <= 1'h1;
        wt(20);
        rc(12'h020, 32'h00000001);
        apb(1'h1, 12'h020, 32'h00010001);
        wt(40);
        rc(12'h020, 32'h01010001);
        n = 0;
        while (card_clk_out !== 1'h0)
            wt(1);
        while (card_clk_out !== 1'h1)
            wt(1);
        while (card_clk_out === 1'h1)
        begin
            n++;
            wt(1);
        end
        chk("half period", n, 32'h00000040);
        socket_idle <= 1'h0;
    endtask
    initial
    begin
        pclk = 1'h0;
        forever
            #50 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_mismatch++;
            give_verdict;
        end
    end
    initial
    begin
        presetn = 1'h0;
        {psel, penable, pwrite, hit, socket_idle, host_clkrun_stopping} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        t_regs;
        t_acc;
        t_stop;
        t_slow;
        give_verdict;
    end
endmodule // tb_cbicc_top
bind cbicc_top cbicc_chk u_chk (.*);
